// file: rtl/cpor_map.svh
// register offsets, field positions, reset values and counts of the phase offset bank
`ifndef CPOR_MAP_SVH
`define CPOR_MAP_SVH

// printed register offsets (not all multiples of four, so each is an index; byte addr = 4*index)
`define CPOR_IDX_CH3_HIGH      8'h8D
`define CPOR_IDX_CH4_LOW       8'h8E
`define CPOR_IDX_CH4_HIGH      8'h8F
`define CPOR_IDX_CH5_LOW       8'h90
`define CPOR_IDX_CH5_HIGH      8'h91
`define CPOR_IDX_CH6_LOW       8'h92
`define CPOR_IDX_CH6_HIGH      8'h93
`define CPOR_IDX_CH7_LOW       8'h94
// first index of the bank and number of byte registers
`define CPOR_IDX_FIRST         8'h8D
`define CPOR_NUM_BYTES         8
// control register of the mode bits, index chosen for this block
`define CPOR_IDX_MODE_CTRL     8'hA0
// mode control field positions
`define CPOR_MODE_OCTAL_BIT    0
`define CPOR_MODE_CW_BIT       1
`define CPOR_MODE_DDC_BIT      2
// reset value of every phase byte
`define CPOR_PHASE_RESET       8'h00
`define CPOR_MODE_RESET        3'h0
// first logical channel held in this bank
`define CPOR_FIRST_CHANNEL     3
`define CPOR_NUM_CHANNELS      5

`endif

// file: rtl/cpor_pkg.sv
// types shared by the phase offset bank
package cpor_pkg;

    // operating mode as seen by the offset path
    typedef enum logic [1:0] {
        CPOR_MODE_OFF,
        CPOR_MODE_CW_OCTAL,
        CPOR_MODE_DDC_NARROW
    } cpor_mode_t;

    typedef logic [15:0] cpor_phase_t;

endpackage

// file: rtl/cpor_phase_add.sv
// adds a channel phase offset to the oscillator phase, gated by mode
`timescale 1ns/1ps
`include "cpor_map.svh"

module cpor_phase_add
    import cpor_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        enable,
    input  wire cpor_phase_t osc_phase,
    input  wire cpor_phase_t offset,
    output cpor_phase_t      mix_phase_q
);

    // ************************************************************
    // registered sum, wraps at a full turn
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mix_phase_q <= 16'h0000;
        end else if (enable) begin
            mix_phase_q <= 16'(osc_phase + offset);
        end else begin
            mix_phase_q <= osc_phase;
        end
    end

endmodule // cpor_phase_add

// file: rtl/cpor_regs.sv
// phase offset register bank for channels 3 to 7, APB slave and offset path
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "cpor_map.svh"

// Contract
// - eight consecutive byte addresses, ch3 high first
// - low byte bits 7:0, next high
// - all-ones word is largest, near full turn
// - 0x00FF is about 1.4 degrees, linear
// - every phase byte clears at reset
// - all bits read and write back
// - logical channel n uses (n+1)th selection
// - offsets act only in CW/DDC modes
module cpor_regs
    import cpor_pkg::*;
#(
    parameter int NUM_CH = `CPOR_NUM_CHANNELS
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_CH*16-1:0] sel_osc_phase,
    output logic      [NUM_CH*16-1:0] sel_mix_phase,
    output logic                      offset_active
);

    // ************************************************************
    // storage
    // ************************************************************
    // byte k of the bank sits at index CPOR_IDX_FIRST + k; byte 0 is ch3 high
    logic [7:0]  bank_q [`CPOR_NUM_BYTES];
    logic [7:0]  ch3_low_shadow;
    logic [2:0]  mode_q;
    logic        access;
    logic [9:0]  word_idx;
    logic        addr_aligned;
    logic        hit_bank;
    logic        hit_mode;
    logic [3:0]  bank_pos;
    logic [31:0] rd_d;
    cpor_mode_t  mode_sel;

    // the low byte of channel 3 lives outside this bank and reads as zero here
    assign ch3_low_shadow = 8'h00;

    // ************************************************************
    // address decode
    // ************************************************************
    assign access       = psel && penable;
    assign word_idx     = paddr[11:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign bank_pos     = 4'(word_idx - 10'(`CPOR_IDX_FIRST));
    // eight consecutive indices from ch3 high to ch7 low
    assign hit_bank     = addr_aligned && (word_idx >= 10'(`CPOR_IDX_CH3_HIGH))
                          && (word_idx <= 10'(`CPOR_IDX_CH7_LOW));
    assign hit_mode     = addr_aligned && (word_idx == 10'(`CPOR_IDX_MODE_CTRL));

    // ************************************************************
    // byte register writes, one per entry
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `CPOR_NUM_BYTES; gi++) begin : g_byte
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    bank_q[gi] <= `CPOR_PHASE_RESET;
                end else if (access && pwrite && hit_bank && pstrb[0]
                             && (bank_pos == 4'(gi))) begin
                    bank_q[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // mode control register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `CPOR_MODE_RESET;
        end else if (access && pwrite && hit_mode && pstrb[0]) begin
            mode_q <= pwdata[2:0];
        end
    end

    // ************************************************************
    // read data and bus answer
    // ************************************************************
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_bank) begin
            rd_d = {24'h00_0000, bank_q[bank_pos[2:0]]};
        end else if (hit_mode) begin
            rd_d = {29'h0000_0000, mode_q};
        end
    end

    // answer in the first access cycle; unmapped addresses flag an error
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !(hit_bank || hit_mode);
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // mode qualification
    // ************************************************************
    // CW beamforming needs octal mode plus down-conversion; narrow modes need down-conversion with octal mode off
    always_comb begin
        mode_sel = CPOR_MODE_OFF;
        if (mode_q[`CPOR_MODE_DDC_BIT]) begin
            if (mode_q[`CPOR_MODE_OCTAL_BIT]) begin
                if (mode_q[`CPOR_MODE_CW_BIT]) begin
                    mode_sel = CPOR_MODE_CW_OCTAL;
                end
            end else begin
                mode_sel = CPOR_MODE_DDC_NARROW;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            offset_active <= 1'b0;
        end else begin
            offset_active <= (mode_sel != CPOR_MODE_OFF);
        end
    end

    // ************************************************************
    // per channel word assembly and phase add
    // ************************************************************
    // slot c carries logical channel 3+c, i.e. selection 4+c of the ordering
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            cpor_phase_t word;
            logic [7:0]  lo;
            logic [7:0]  hi;
            if (gi == 0) begin : g_first
                assign lo = ch3_low_shadow;
                assign hi = bank_q[0];
            end else if (gi == NUM_CH - 1) begin : g_last
                assign lo = bank_q[2*gi-1];
                assign hi = 8'h00;
            end else begin : g_mid
                assign lo = bank_q[2*gi-1];
                assign hi = bank_q[2*gi];
            end
            assign word = {hi, lo};

            cpor_phase_add u_add (
                .clk         (clk),
                .resetn      (resetn),
                .enable      (offset_active),
                .osc_phase   (sel_osc_phase[gi*16 +: 16]),
                .offset      (word),
                .mix_phase_q (sel_mix_phase[gi*16 +: 16])
            );
        end
    endgenerate

endmodule // cpor_regs

// file: verif/cpor_regs_sva.sv
// assertion checker for the phase offset bank ports
`timescale 1ns/1ps
module cpor_regs_sva #(
    parameter int NUM_CH = 5
) (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 offset_active,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic [3:0]           pstrb,
    input wire logic [NUM_CH*16-1:0] sel_osc_phase,
    input wire logic [NUM_CH*16-1:0] sel_mix_phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ************************************
    // mode register write as seen on apb
    // ************************************
    sequence s_mode_wr(logic [2:0] m);
        psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h280 && pwdata[2:0] == m;
    endsequence
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_access: assert property (psel && penable && !$past(penable) |-> pready)
        else $error("no ready in first access cycle");
    chk_ready_idle: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_err_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    chk_err_bank: assert property (pready && paddr >= 12'h234 && paddr <= 12'h250
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("bank access refused");
    // mode lands at the access edge, the qualified flag one edge later
    chk_mode_on: assert property (s_mode_wr(3'h4) |-> ##2 offset_active)
        else $error("offsets not enabled");
    chk_mode_off: assert property (s_mode_wr(3'h1) |-> ##2 !offset_active)
        else $error("offsets enabled in octal without cw");
    chk_mix_bypass: assert property (!offset_active [*3]
        |-> sel_mix_phase == $past(sel_osc_phase))
        else $error("phase altered while inactive");
endmodule // cpor_regs_sva

bind cpor_regs cpor_regs_sva #(.NUM_CH(NUM_CH)) u_sva (.*);

// file: verif/tb_top.sv
// self-checking bench for the phase offset bank
`timescale 1ns/1ps
module tb_top;
    logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, offset_active;
    logic [79:0] osc = '0, mix;
    logic [32:0] expq[$];
    logic [7:0]  img[8];
    logic [15:0] w;
    logic        act;
    int          miscompares = 0, samples_checked = 0;
    cpor_regs DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sel_osc_phase(osc), .sel_mix_phase(mix),
        .offset_active(offset_active));
    // clock at 200 MHz
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one apb transfer, expected {pslverr, prdata} noted first
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        expq.push_back(e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // answer monitor takes the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            chk({pslverr, prdata}, expq.pop_front());
        end
    end
    // watchdog
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(80));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) apb(0, 12'h234 + 12'(4 * i), '0, '0);
        w = 16'(65536 * 100 / 360); // word for 100 degrees
        for (int i = 0; i < 8; i++) begin
            img[i] = (i == 1 || i == 2 || i == 7) ? 8'hFF : 8'($urandom);
            img[i] = (i == 5) ? w[7:0] : (i == 6) ? w[15:8] : img[i];
            apb(1, 12'h234 + 12'(4 * i), {24'($urandom), img[i]}, '0);
        end
        // a write without lane 0 must leave the byte alone
        pstrb <= 4'hE;
        apb(1, 12'h234, {24'h00_0000, ~img[0]}, '0);
        pstrb <= 4'hF;
        for (int i = 0; i < 8; i++) apb(0, 12'h234 + 12'(4 * i), '0, {25'h0, img[i]});
        apb(0, 12'h230, '0, 33'h1_0000_0000);
        apb(1, 12'h235, 32'hFF, 33'h1_0000_0000);
        $display("register test done");
        for (int m = 0; m < 8; m++) begin
            apb(1, 12'h280, 32'(m), '0);
            osc <= {16'($urandom), 32'($urandom), 32'($urandom)};
            repeat (3) @(posedge clk);
            act = m[2] & ((m[0] & m[1]) | !m[0]);
            chk(33'(offset_active), 33'(act));
            for (int c = 0; c < 5; c++) begin
                w = {(c == 4) ? 8'h00 : img[2 * c], (c == 0) ? 8'h00 : img[2 * c - 1]};
                chk(33'(mix[c * 16+:16]), 33'(16'(osc[c * 16+:16] + (act ? w : 16'h0))));
            end
        end
        // every answer must have met a note, and no answer may be missing
        chk(33'(expq.size()), 33'h0);
        $display("offset path test done");
        tally_and_finish();
    end
endmodule // tb_top
